// [rtl/ldh_pkg.sv]
// package: constants and types of the lin diagnostic service handler
package ldh_pkg;

  // ==========================================================================
  // frame identifiers (protected form, parity bits included)
  localparam logic [7:0] LDH_PID_REQ     = 8'h3C;
  localparam logic [7:0] LDH_PID_RSP     = 8'h7D;

  // ==========================================================================
  // request and response field values
  localparam logic [7:0] LDH_NAD_WILD    = 8'h7F;
  localparam logic [7:0] LDH_PCI_RBI     = 8'h06;
  localparam logic [7:0] LDH_SID_RBI     = 8'hB2;
  localparam logic [7:0] LDH_RSID_POS    = 8'hF2;
  localparam logic [7:0] LDH_PCI_NEG     = 8'h03;
  localparam logic [7:0] LDH_RSID_NEG    = 8'h7F;
  localparam logic [7:0] LDH_ERR_OOR     = 8'h12;
  localparam logic [7:0] LDH_PAD         = 8'hFF;
  localparam logic [7:0] LDH_PCI_RST     = 8'h01;
  localparam logic [7:0] LDH_SID_RST     = 8'hB5;
  localparam logic [7:0] LDH_SUP_WILD_LO = 8'hFF;
  localparam logic [7:0] LDH_SUP_WILD_HI = 8'h7F;
  localparam logic [7:0] LDH_FUN_WILD    = 8'hFF;

  // ==========================================================================
  // node identifiers inside the virtual node
  localparam logic [7:0] LDH_NID_PRIME   = 8'h00;
  localparam logic [7:0] LDH_NID_A       = 8'h20;
  localparam logic [7:0] LDH_NID_D       = 8'h23;

  // ==========================================================================
  // frame layout and reset values
  localparam int         LDH_DATA_BYTES  = 8;
  localparam logic [3:0] LDH_LAST_IDX    = 4'h8;
  localparam logic [2:0] LDH_ERR_RST     = 3'b000;
  localparam logic [2:0] LDH_ERR_TGT     = 3'b001;
  localparam logic [7:0] LDH_BYTE_RST    = 8'h00;

  // ==========================================================================
  // types
  typedef struct packed {
    logic       valid;
    logic [7:0] pid;
  } ldh_hdr_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ldh_byte_stb_t;

  typedef enum logic [3:0] {
    LDH_S_IDLE = 4'b0001,
    LDH_S_RX   = 4'b0010,
    LDH_S_WAIT = 4'b0100,
    LDH_S_TX   = 4'b1000
  } ldh_state_t;

endpackage : ldh_pkg

// [rtl/ldh_checksum.sv]
// module: classic lin checksum accumulator with end-around carry
`timescale 1ns/1ps
`default_nettype none
module ldh_checksum (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // accumulate control
  input  wire logic       clr_i,
  input  wire logic       add_i,
  input  wire logic [7:0] data_i,
  // results
  output logic      [7:0] chk_o,
  output logic      [7:0] chk_with_o
);
  import ldh_pkg::*;

  logic [7:0] acc_r;
  logic [8:0] sum_w;
  logic [7:0] fold_w;

  // ==========================================================================
  // carry is folded back in, so the sum never loses a wrap
  assign sum_w      = {1'b0, acc_r} + {1'b0, data_i};
  assign fold_w     = sum_w[7:0] + {7'b000_0000, sum_w[8]};
  assign chk_o      = ~acc_r;
  assign chk_with_o = ~fold_w;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      acc_r <= LDH_BYTE_RST;
    end else if (clr_i) begin
      acc_r <= LDH_BYTE_RST;
    end else if (add_i) begin
      acc_r <= fold_w;
    end
  end
endmodule : ldh_checksum
`default_nettype wire

// [rtl/ldh_service_handler.sv]
// module: lin node-configuration and diagnostic service handler
//
// Function
// R1: requests arrive in frame id 0x3C
// R2: decode read-by-identifier, length 0x06, service 0xB2
// R3: accept own node address or wildcard 0x7F
// R4: node identifier byte picks replying member
// R5: match supplier/function codes, wildcards always match
// R6: 0x00 prime, 0x20..0x23 members A..D
// R7: prime answers 0x00 or its letter
// R8: positive response: address, 0x06, 0xF2, codes, version
// R9: out of range: prime sends 0x7F negative
// R10: broadcast reset resets node, no response
// R11: recognise targeted reset with padding bytes
// R12: targeted reset switches all outputs off
// R13: targeted reset clears flags two, three; sets one
// R14: respond in 0x3D; classic checksum both ways
// R15: foreign address ignored, slot left silent
`timescale 1ns/1ps
`default_nettype none
module ldh_service_handler #(
  parameter logic [15:0] SUPPLIER_ID  = 16'h1357, // arbitrary value
  parameter logic [15:0] FUNCTION_ID  = 16'h2468, // arbitrary value
  parameter logic [7:0]  SILICON_VER  = 8'h01     // arbitrary value
) (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  // frame layer receive side
  input  wire ldh_pkg::ldh_hdr_t      hdr_i,
  input  wire ldh_pkg::ldh_byte_stb_t rx_i,
  input  wire logic                   frame_abort_i,
  // frame layer transmit side
  output logic                        tx_valid_o,
  output logic [7:0]                  tx_byte_o,
  input  wire logic                   tx_ready_i,
  // node configuration
  input  wire logic [7:0]             node_address_i,
  input  wire logic                   is_prime_i,
  input  wire logic [1:0]             member_pos_i,
  // error status
  input  wire logic [2:0]             err_set_i,
  output logic [2:0]                  err_flags_o,
  // service effects
  output logic                        outputs_off_o,
  output logic                        node_reset_o,
  output logic                        chk_error_o
);
  import ldh_pkg::*;

  // ==========================================================================
  // decode helpers
  function automatic logic is_pad(input logic [7:0] b);
    is_pad = (b == LDH_PAD);
  endfunction : is_pad

  function automatic logic nid_in_range(input logic [7:0] nid);
    nid_in_range = (nid == LDH_NID_PRIME) || ((nid >= LDH_NID_A) && (nid <= LDH_NID_D));
  endfunction : nid_in_range

  // ==========================================================================
  // storage
  ldh_state_t state_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] tx_cnt_r;
  logic [7:0] req_r  [LDH_DATA_BYTES];
  logic [7:0] resp_r [LDH_DATA_BYTES];
  logic [7:0] resp_nxt [LDH_DATA_BYTES];
  logic [7:0] tx_byte_r;
  logic [2:0] err_r;
  logic       off_r;
  logic       nrst_r;
  logic       chk_err_r;

  logic [7:0] rx_chk;
  logic [7:0] tx_chk_with;
  logic       hdr_req;
  logic       hdr_rsp;
  logic       rx_add;
  logic       frame_done;
  logic       chk_ok;
  logic       tx_fire;
  logic       addr_own;
  logic       addr_ok;
  logic       sup_ok;
  logic       fun_ok;
  logic       rbi_req;
  logic       rst_req;
  logic       rbi_mine;
  logic       rbi_pos;
  logic       rbi_neg;
  logic       tgt_rst;
  logic       bc_rst;
  logic       resp_load;
  logic [7:0] own_nid;

  assign hdr_req    = hdr_i.valid && (hdr_i.pid == LDH_PID_REQ); // R1
  assign hdr_rsp    = hdr_i.valid && (hdr_i.pid == LDH_PID_RSP); // R14
  assign rx_add     = (state_r == LDH_S_RX) && rx_i.valid && (rx_cnt_r < LDH_LAST_IDX);
  assign frame_done = (state_r == LDH_S_RX) && rx_i.valid && (rx_cnt_r == LDH_LAST_IDX);
  assign chk_ok     = (rx_i.data == rx_chk); // R14
  assign tx_fire    = (state_r == LDH_S_TX) && tx_ready_i;

  // ==========================================================================
  // checksums for request and response
  ldh_checksum u_rx_chk (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .clr_i      (hdr_i.valid),
    .add_i      (rx_add),
    .data_i     (rx_i.data),
    .chk_o      (rx_chk),
    .chk_with_o ()
  );

  ldh_checksum u_tx_chk (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .clr_i      (hdr_i.valid),
    .add_i      (tx_fire && (tx_cnt_r < LDH_LAST_IDX)),
    .data_i     (tx_byte_r),
    .chk_o      (),
    .chk_with_o (tx_chk_with)
  );

  // ==========================================================================
  // request decode
  assign addr_own = (req_r[0] == node_address_i);
  assign addr_ok  = addr_own || (req_r[0] == LDH_NAD_WILD); // R3
  assign sup_ok   = ((req_r[4] == SUPPLIER_ID[7:0]) && (req_r[5] == SUPPLIER_ID[15:8]))
                 || ((req_r[4] == LDH_SUP_WILD_LO) && (req_r[5] == LDH_SUP_WILD_HI)); // R5
  assign fun_ok   = ((req_r[6] == FUNCTION_ID[7:0]) && (req_r[7] == FUNCTION_ID[15:8]))
                 || ((req_r[6] == LDH_FUN_WILD) && (req_r[7] == LDH_FUN_WILD)); // R5
  assign rbi_req  = (req_r[1] == LDH_PCI_RBI) && (req_r[2] == LDH_SID_RBI); // R2
  assign rst_req  = (req_r[1] == LDH_PCI_RST) && (req_r[2] == LDH_SID_RST)
                 && is_pad(req_r[3]) && is_pad(req_r[4]) && is_pad(req_r[5])
                 && is_pad(req_r[6]) && is_pad(req_r[7]); // R11
  assign own_nid  = LDH_NID_A + {6'b00_0000, member_pos_i}; // R6
  // a non-prime member never sees 0x00 as its own, so only the prime answers it
  assign rbi_mine = ((req_r[3] == LDH_NID_PRIME) && is_prime_i) || (req_r[3] == own_nid); // R4 R7
  assign rbi_pos  = addr_ok && rbi_req && sup_ok && fun_ok && nid_in_range(req_r[3])
                 && rbi_mine; // R8
  assign rbi_neg  = addr_ok && rbi_req && sup_ok && fun_ok && !nid_in_range(req_r[3])
                 && is_prime_i; // R9
  assign tgt_rst  = addr_own && rst_req; // R11
  assign bc_rst   = (req_r[0] == LDH_NAD_WILD) && rst_req; // R10
  // resets and foreign addresses never load a response
  assign resp_load = frame_done && chk_ok && (rbi_pos || rbi_neg); // R15

  always_comb begin
    for (int i = 0; i < LDH_DATA_BYTES; i++) begin
      resp_nxt[i] = LDH_PAD;
    end
    resp_nxt[0] = node_address_i;
    if (rbi_neg) begin
      resp_nxt[1] = LDH_PCI_NEG; // R9
      resp_nxt[2] = LDH_RSID_NEG;
      resp_nxt[3] = LDH_SID_RBI;
      resp_nxt[4] = LDH_ERR_OOR;
    end else begin
      resp_nxt[1] = LDH_PCI_RBI; // R8
      resp_nxt[2] = LDH_RSID_POS;
      resp_nxt[3] = SUPPLIER_ID[7:0];
      resp_nxt[4] = SUPPLIER_ID[15:8];
      resp_nxt[5] = FUNCTION_ID[7:0];
      resp_nxt[6] = FUNCTION_ID[15:8];
      resp_nxt[7] = SILICON_VER;
    end
  end

  // ==========================================================================
  // frame sequencing; a new header always restarts, so a pending answer
  // is dropped unless the very next header is the response slot
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= LDH_S_IDLE;
    end else if (hdr_i.valid) begin
      if (hdr_req) begin
        state_r <= LDH_S_RX;
      end else if (hdr_rsp && (state_r == LDH_S_WAIT)) begin
        state_r <= LDH_S_TX; // R14
      end else begin
        state_r <= LDH_S_IDLE;
      end
    end else if (frame_abort_i) begin
      state_r <= LDH_S_IDLE;
    end else begin
      case (state_r)
        LDH_S_IDLE: state_r <= LDH_S_IDLE;
        LDH_S_RX: begin
          if (frame_done) begin
            state_r <= resp_load ? LDH_S_WAIT : LDH_S_IDLE;
          end
        end
        LDH_S_WAIT: state_r <= LDH_S_WAIT;
        LDH_S_TX: begin
          if (tx_fire && (tx_cnt_r == LDH_LAST_IDX)) begin
            state_r <= LDH_S_IDLE;
          end
        end
        default: state_r <= LDH_S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // request capture
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_cnt_r <= 4'h0;
    end else if (hdr_i.valid) begin
      rx_cnt_r <= 4'h0;
    end else if (rx_add) begin
      rx_cnt_r <= rx_cnt_r + 4'h1;
    end
  end

  generate
    for (genvar g = 0; g < LDH_DATA_BYTES; g++) begin : g_req
      always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
          req_r[g]  <= LDH_BYTE_RST;
          resp_r[g] <= LDH_BYTE_RST;
        end else begin
          if (rx_add && (rx_cnt_r == 4'(g))) begin
            req_r[g] <= rx_i.data;
          end
          if (resp_load) begin
            resp_r[g] <= resp_nxt[g];
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // response transmit
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_cnt_r  <= 4'h0;
      tx_byte_r <= LDH_BYTE_RST;
    end else if (hdr_rsp && (state_r == LDH_S_WAIT)) begin
      tx_cnt_r  <= 4'h0;
      tx_byte_r <= resp_r[0];
    end else if (tx_fire && (tx_cnt_r < LDH_LAST_IDX)) begin
      tx_cnt_r  <= tx_cnt_r + 4'h1;
      tx_byte_r <= (tx_cnt_r == (LDH_LAST_IDX - 4'h1)) ? tx_chk_with
                                                       : resp_r[3'(tx_cnt_r + 4'h1)]; // R14
    end
  end

  assign tx_valid_o = (state_r == LDH_S_TX);
  assign tx_byte_o  = tx_byte_r;

  // ==========================================================================
  // reset services and error status; a fresh error event wins over the clear
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      off_r     <= 1'b0;
      nrst_r    <= 1'b0;
      chk_err_r <= 1'b0;
    end else begin
      off_r     <= frame_done && chk_ok && tgt_rst; // R12
      nrst_r    <= frame_done && chk_ok && bc_rst; // R10
      chk_err_r <= frame_done && !chk_ok; // R14
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      err_r <= LDH_ERR_RST;
    end else if (frame_done && chk_ok && tgt_rst) begin
      err_r <= LDH_ERR_TGT | {err_set_i[2:1], 1'b0}; // R13
    end else begin
      err_r <= err_r | err_set_i;
    end
  end

  assign outputs_off_o = off_r;
  assign node_reset_o  = nrst_r;
  assign chk_error_o   = chk_err_r;
  assign err_flags_o   = err_r;
endmodule : ldh_service_handler
`default_nettype wire

// [verif/ldh_chk.sv]
// checker: port-level assertions of the lin diagnostic service handler
`timescale 1ns/1ps
`default_nettype none
module ldh_chk (
  // clock and reset
  input wire logic                   clk_i,
  input wire logic                   reset_n_i,
  // frame layer
  input wire ldh_pkg::ldh_hdr_t      hdr_i,
  input wire ldh_pkg::ldh_byte_stb_t rx_i,
  input wire logic                   frame_abort_i,
  input wire logic                   tx_valid_o,
  input wire logic [7:0]             tx_byte_o,
  input wire logic                   tx_ready_i,
  // config, flags, effects
  input wire logic [7:0]             node_address_i,
  input wire logic [2:0]             err_set_i,
  input wire logic [2:0]             err_flags_o,
  input wire logic                   outputs_off_o,
  input wire logic                   node_reset_o,
  input wire logic                   chk_error_o
);
  import ldh_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================================================
  // response side
  AST_TX_OPEN: assert property ($rose(tx_valid_o) |-> $past(hdr_i.valid) &&
    $past(hdr_i.pid) == LDH_PID_RSP) else $error("response opened without slot header");
  AST_TX_ADDR: assert property ($rose(tx_valid_o) |-> tx_byte_o == node_address_i)
    else $error("first response byte is not own address");
  // a stalled byte must not slip, or the master reads a gap
  AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i && !hdr_i.valid &&
    !frame_abort_i |=> tx_valid_o && $stable(tx_byte_o)) else $error("byte changed unread");
  AST_TX_END: assert property ($fell(tx_valid_o) |-> $past(tx_ready_i) ||
    $past(hdr_i.valid) || $past(frame_abort_i)) else $error("response dropped unread");
  // ==========================================================================
  // service effects
  AST_OFF_FLAGS: assert property (outputs_off_o |-> $past(rx_i.valid) && err_flags_o[0] &&
    err_flags_o[2:1] == $past(err_set_i[2:1])) else $error("targeted reset flags wrong");
  AST_OFF_PULSE: assert property (outputs_off_o |=> !outputs_off_o)
    else $error("outputs off pulse too long");
  AST_RST_QUIET: assert property (node_reset_o |-> $past(rx_i.valid) && !tx_valid_o &&
    !outputs_off_o) else $error("broadcast reset misbehaved");
  AST_CHK_ERR: assert property (chk_error_o |-> $past(rx_i.valid) && !outputs_off_o &&
    !node_reset_o) else $error("checksum error pulse misplaced");
  AST_ERR_SET: assert property (|err_set_i |=>
    (err_flags_o & $past(err_set_i)) == $past(err_set_i)) else $error("error event lost");
endmodule : ldh_chk
bind ldh_service_handler ldh_chk ldh_chk_inst (.clk_i, .reset_n_i, .hdr_i, .rx_i,
  .frame_abort_i, .tx_valid_o, .tx_byte_o, .tx_ready_i, .node_address_i, .err_set_i,
  .err_flags_o, .outputs_off_o, .node_reset_o, .chk_error_o);
`default_nettype wire

// [verif/ldh_lin_master.sv]
// partner: behavioural lin master that frames requests and collects responses
`timescale 1ns/1ps
`default_nettype none
module ldh_lin_master (
  // clock
  input  wire logic                  clk_i,
  // header and request bytes
  output var ldh_pkg::ldh_hdr_t      hdr_o,
  output var ldh_pkg::ldh_byte_stb_t rx_o,
  // response side
  input  wire logic                  tx_valid_i,
  input  wire logic [7:0]            tx_byte_i,
  output logic                       tx_ready_o
);
  import ldh_pkg::*;
  initial begin
    hdr_o <= '0;
    rx_o <= '0;
    tx_ready_o <= 1'b0;
  end
  // ==========================================================================
  // classic checksum, pid left out
  function automatic logic [7:0] csum(input logic [63:0] d);
    logic [8:0] s;
    s = '0;
    for (int i = 0; i < 8; i++) begin
      s = {1'b0, s[7:0]} + {1'b0, d[63-8*i -: 8]};
      s = {1'b0, s[7:0]} + {8'h00, s[8]};
    end
    return ~s[7:0];
  endfunction : csum
  // request frame; bad flips the low bit of the checksum on purpose
  task automatic send_req(input logic [63:0] d, input logic bad);
    @(posedge clk_i);
    hdr_o <= '{1'b1, LDH_PID_REQ};
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_i);
      hdr_o <= '{1'b0, ~LDH_PID_REQ};
      rx_o <= '{1'b1, (i < 8) ? d[63-8*i -: 8] : csum(d) ^ {7'h00, bad}};
    end
    @(posedge clk_i);
    // idle data shows junk, never the last byte
    rx_o <= '{1'b0, ~rx_o.data};
  endtask : send_req
  // response slot; slow stalls every other cycle
  task automatic fetch(input logic slow, output logic [71:0] r, output int n);
    r = '0;
    n = 0;
    @(posedge clk_i);
    hdr_o <= '{1'b1, LDH_PID_RSP};
    for (int c = 0; c < 30; c++) begin
      @(posedge clk_i);
      if (tx_valid_i && tx_ready_o) begin
        r = {r[63:0], tx_byte_i};
        n++;
      end
      hdr_o <= '{1'b0, ~LDH_PID_RSP};
      // ready drops on the last slot cycle, so the next frame starts clean
      tx_ready_o <= (c < 29) && (!slow || c[0]);
    end
  endtask : fetch
endmodule : ldh_lin_master
`default_nettype wire

// [verif/tb_ldh_service_handler.sv]
// testbench: self-checking scenarios of the lin diagnostic service handler
`timescale 1ns/1ps
`default_nettype none
module tb_ldh_service_handler;
  import ldh_pkg::*;
  localparam logic [7:0]  NODE = 8'h5A;
  localparam logic [55:0] POS  = 56'h06_F257_1368_2401;
  localparam logic [55:0] NEG  = 56'h03_7FB2_12FF_FFFF;
  logic          clk_i, reset_n_i, frame_abort_i, is_prime_i, tx_ready_i;
  logic          tx_valid_o, outputs_off_o, node_reset_o, chk_error_o;
  logic [1:0]    member_pos_i;
  logic [2:0]    err_set_i, err_flags_o;
  logic [7:0]    tx_byte_o;
  logic [71:0]   r;
  ldh_hdr_t      hdr_i;
  ldh_byte_stb_t rx_i;
  int            n_errors = 0, check_count = 0, cyc = 0, n_off = 0, n_nrst = 0, n_cerr = 0, n;
  // identity codes are arbitrary
  ldh_service_handler #(.SUPPLIER_ID(16'h1357), .FUNCTION_ID(16'h2468), .SILICON_VER(8'h01))
    ldh_service_handler_inst (.clk_i, .reset_n_i, .hdr_i, .rx_i, .frame_abort_i, .tx_valid_o,
    .tx_byte_o, .tx_ready_i, .node_address_i(NODE), .is_prime_i, .member_pos_i, .err_set_i,
    .err_flags_o, .outputs_off_o, .node_reset_o, .chk_error_o);
  ldh_lin_master ldh_lin_master_inst (.clk_i, .hdr_o(hdr_i), .rx_o(rx_i),
    .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o), .tx_ready_o(tx_ready_i));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // pulse counters and the hang guard
  always @(posedge clk_i) begin
    cyc++;
    n_off += outputs_off_o;
    n_nrst += node_reset_o;
    n_cerr += chk_error_o;
    if (cyc == 6000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ==========================================================================
  // helpers
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [71:0] rsp(input logic [63:0] d);
    return {d, ldh_lin_master_inst.csum(d)};
  endfunction : rsp
  task automatic xfer(input logic [63:0] d, input logic bad, input logic slow, input int en,
                      input logic [71:0] er);
    ldh_lin_master_inst.send_req(d, bad);
    ldh_lin_master_inst.fetch(slow, r, n);
    chk(72'(n), 72'(en));
    if (en == 9)
      chk(r, er);
  endtask : xfer
  // ==========================================================================
  // scenarios
  task automatic t_select;
    is_prime_i <= 1'b1;
    member_pos_i <= 2'd1;
    xfer({NODE, 56'h06_B200_5713_6824}, 0, 0, 9, rsp({NODE, POS}));
    xfer({8'h7F, 56'h06_B221_FF7F_FFFF}, 0, 1, 9, rsp({NODE, POS}));
    xfer({NODE, 56'h06_B224_5713_6824}, 0, 1, 9, rsp({NODE, NEG}));
    xfer({NODE, 56'h06_B21F_5713_FFFF}, 0, 0, 9, rsp({NODE, NEG}));
    is_prime_i <= 1'b0;
    member_pos_i <= 2'd2;
    xfer({NODE, 56'h06_B222_5713_6824}, 0, 0, 9, rsp({NODE, POS}));
    xfer({NODE, 56'h06_B200_5713_6824}, 0, 0, 0, '0);
    xfer({NODE, 56'h06_B223_5713_6824}, 0, 0, 0, '0);
    xfer({NODE, 56'h06_B224_5713_6824}, 0, 0, 0, '0);
  endtask : t_select
  task automatic t_refuse;
    int c0;
    is_prime_i <= 1'b1;
    xfer({8'h5B, 56'h06_B200_5713_6824}, 0, 0, 0, '0);
    xfer({NODE, 56'h06_B200_5813_6824}, 0, 0, 0, '0);
    xfer({NODE, 56'h06_B300_5713_6824}, 0, 0, 0, '0);
    c0 = n_cerr;
    xfer({NODE, 56'h06_B200_5713_6824}, 1, 1, 0, '0);
    chk(72'(n_cerr - c0), 72'd1);
    ldh_lin_master_inst.send_req({NODE, 56'h06_B200_5713_6824}, 1'b0);
    frame_abort_i <= 1'b1;
    @(posedge clk_i);
    frame_abort_i <= 1'b0;
    ldh_lin_master_inst.fetch(1'b0, r, n);
    chk(72'(n), 72'd0);
  endtask : t_refuse
  task automatic t_reset;
    int o0;
    err_set_i <= 3'b110;
    @(posedge clk_i);
    err_set_i <= 3'b000;
    repeat (2) @(posedge clk_i);
    chk(72'(err_flags_o), 72'h6);
    o0 = n_off;
    xfer({NODE, 56'h01_B5FF_FFFF_FFFF}, 0, 0, 0, '0);
    chk(72'(n_off - o0), 72'd1);
    chk(72'(err_flags_o), 72'h1);
    xfer({NODE, 56'h01_B5FF_FFFF_FFFE}, 0, 0, 0, '0);
    chk(72'(n_off - o0), 72'd1);
    o0 = n_nrst;
    xfer({8'h7F, 56'h01_B5FF_FFFF_FFFF}, 0, 1, 0, '0);
    chk(72'(n_nrst - o0), 72'd1);
  endtask : t_reset
  initial begin
    reset_n_i <= 1'b0;
    frame_abort_i <= 1'b0;
    is_prime_i <= 1'b1;
    member_pos_i <= 2'd0;
    err_set_i <= 3'b000;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    chk(72'({tx_valid_o, err_flags_o, tx_byte_o, outputs_off_o, node_reset_o, chk_error_o}),
        72'h0);
    t_select();
    t_refuse();
    t_reset();
    print_verdict();
  end
endmodule : tb_ldh_service_handler
`default_nettype wire
